// >>> src/prfa_decoder.v
// Purpose: Register file and program memory address decoding with paging
// Assumes: Core issues one register access per cycle, synchronous inputs
// Notes: Storage is an internal array; set 1 bank area held here too
`timescale 1ns/1ps
`default_nettype none
`include "prfa_regs.vh"

// Functional notes
// - Program fetch starts at 0100H after reset
// - Lowest 256 ROM bytes vectors, still fetchable
// - 16-bit program bus, 8-bit register bus
// - 48 Kbytes of ROM reachable
// - Set 1 page-independent, direct addressing only
// - E0H-FFH banked, reset selects bank 0
// - D0H-DFH system; C0H-CFH working-mode only
// - Set 2 per page, indirect or indexed only
// - Prime area 00H-BFH accepts every mode
// - Page pointer at DFH, reset to zero
// - Sixteen logical pages, eight implemented
// - 20 display bytes in paged prime area
// - Slice is eight registers, two form block
// - Pointers at D6H/D7H, reset C0H and C8H
// - Pointers written by set-pointer or load
// - Working addressing never reaches set 2
// - 4-bit address: top bit picks pointer
// - Upper nibble 1100B means working reference
// - Register pairs: even MSB, odd LSB
module prfa_decoder (
    input wire clk,
    input wire sys_rst,
    input wire fetchNext,
    input wire jumpValid,
    input wire [15:0] jumpAddr,
    output reg [15:0] progAddr,
    output wire progVector,
    output wire progInRange,
    input wire regReq,
    input wire regWrite,
    input wire regPair,
    input wire [2:0] regMode,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regWdataLow,
    input wire setPointerInstr,
    input wire setPointerSel,
    input wire [7:0] setPointerVal,
    input wire selectBankZeroInstr,
    input wire selectBankOneInstr,
    output reg [7:0] regRdata,
    output reg [7:0] regRdataLow,
    output reg regErr,
    output reg regAck,
    output wire [7:0] workingPtrLow,
    output wire [7:0] workingPtrHigh,
    output wire [7:0] pageSelectPointer,
    output wire bankSel,
    output wire displayHit
);
    reg [15:0] progAddr_ff;
    reg [7:0] workingPtrLow_ff;
    reg [7:0] workingPtrHigh_ff;
    reg [7:0] pageSelect_ff;
    reg bank_ff;
    // Prime and set 2 storage per implemented page, plus set 1 pieces
    reg [7:0] pagedMem [0:2047];
    reg [7:0] commonMem [0:15];
    reg [7:0] sysMem [0:15];
    reg [7:0] bankMem [0:63];

    wire [7:0] wrAddr;
    wire isWrRef;
    reg [7:0] effAddr;
    reg [3:0] pageSel;
    reg inSet1;
    reg legal;
    reg [10:0] pagedIdx;
    wire [7:0] pairAddr;
    wire ptrLoad;
    wire pairToHigh;
    wire pairToPage;

    // Program counter: reset start, sequential fetch, jumps anywhere
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            progAddr_ff <= `PRFA_RESET_PC;
        end else if (jumpValid) begin
            progAddr_ff <= jumpAddr;
        end else if (fetchNext) begin
            progAddr_ff <= progAddr_ff + 16'h0001;
        end
    end

    always @* begin
        progAddr = progAddr_ff;
    end

    // Vector area is flagged but still fetched as code
    assign progVector = (progAddr_ff <= `PRFA_VECTOR_TOP);
    assign progInRange = (progAddr_ff <= `PRFA_ROM_TOP);

    // 8-bit form with 1100B upper nibble reuses the 4-bit mapping
    assign isWrRef = (regMode == `PRFA_MODE_WREG4) ||
                     (regMode == `PRFA_MODE_REG &&
                      regAddr[7:4] == `PRFA_WR_NIBBLE);

    prfa_wreg_map uMap (
        .wrNibble(regAddr[3:0]),
        .workingPtrLow(workingPtrLow_ff),
        .workingPtrHigh(workingPtrHigh_ff),
        .fullAddr(wrAddr)
    );

    // Address class decode; upper region meaning depends on mode
    always @* begin
        effAddr = isWrRef ? wrAddr : regAddr;
        // Source nibble for reads, destination nibble for writes
        pageSel = regWrite ? pageSelect_ff[7:4] : pageSelect_ff[3:0];
        // Indirect and indexed reach set 2; register and 4-bit working modes reach set 1
        inSet1 = (effAddr >= `PRFA_SET1_BASE) &&
                 (regMode == `PRFA_MODE_REG ||
                  regMode == `PRFA_MODE_WREG4);
        legal = 1'b1;
        // Only the set 1 copy is guarded; set 2 C0H-CFH stays open
        if (inSet1 && effAddr <= `PRFA_COMMON_TOP && !isWrRef) begin
            legal = 1'b0;
        end
        // Pages 8..15 exist logically only; no storage behind them
        if (!inSet1 && pageSel >= `PRFA_PAGE_COUNT) begin
            legal = 1'b0;
        end
        if (regPair && effAddr[0]) begin
            legal = 1'b0;
        end
        if (regMode > `PRFA_MODE_INDEXED && effAddr >= `PRFA_SET1_BASE) begin
            legal = 1'b0;
        end
        // Prime area accepts every mode, set 2 lives in same page slot
        pagedIdx = {pageSel[2:0], effAddr};
    end

    // Odd partner holds the low byte of a pair
    assign pairAddr = {effAddr[7:1], 1'b1};

    // Offset form avoids an always-true compare when the base is zero
    assign displayHit = regReq && !inSet1 &&
                        (effAddr - `PRFA_DISPLAY_BASE) <
                        `PRFA_DISPLAY_LEN;

    // Load qualifiers for the live set 1 registers, pair halves included
    assign ptrLoad = regReq && regWrite && legal && inSet1;
    assign pairToHigh = ptrLoad && regPair &&
                        (pairAddr == `PRFA_WP_HIGH_ADDR);
    assign pairToPage = ptrLoad && regPair &&
                        (pairAddr == `PRFA_PAGE_PTR_ADDR);

    // Pointers, page select and bank: hardware instructions and loads
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            workingPtrLow_ff <= `PRFA_WP_LOW_RST;
            workingPtrHigh_ff <= `PRFA_WP_HIGH_RST;
            pageSelect_ff <= `PRFA_PAGE_PTR_RST;
            bank_ff <= 1'b0;
        end else begin
            if (selectBankOneInstr) begin
                bank_ff <= 1'b1;
            end else if (selectBankZeroInstr) begin
                bank_ff <= 1'b0;
            end
            // Set-pointer beats a same-cycle load of its own pointer only
            if (setPointerInstr && !setPointerSel) begin
                workingPtrLow_ff <= setPointerVal;
            end else if (ptrLoad && effAddr == `PRFA_WP_LOW_ADDR) begin
                workingPtrLow_ff <= regWdata;
            end
            if (setPointerInstr && setPointerSel) begin
                workingPtrHigh_ff <= setPointerVal;
            end else if (ptrLoad && effAddr == `PRFA_WP_HIGH_ADDR) begin
                workingPtrHigh_ff <= regWdata;
            end else if (pairToHigh) begin
                workingPtrHigh_ff <= regWdataLow;
            end
            // Page pointer loads are never lost to a pointer strobe
            if (ptrLoad && effAddr == `PRFA_PAGE_PTR_ADDR) begin
                pageSelect_ff <= regWdata;
            end else if (pairToPage) begin
                pageSelect_ff <= regWdataLow;
            end
        end
    end

    assign workingPtrLow = workingPtrLow_ff;
    assign workingPtrHigh = workingPtrHigh_ff;
    assign pageSelectPointer = pageSelect_ff;
    assign bankSel = bank_ff;

    // Storage writes; arrays have no reset, contents undefined at start
    always @(posedge clk) begin
        if (regReq && regWrite && legal) begin
            if (!inSet1) begin
                pagedMem[pagedIdx] <= regWdata;
                if (regPair) begin
                    pagedMem[{pageSel[2:0], pairAddr}] <= regWdataLow;
                end
            end else if (effAddr <= `PRFA_COMMON_TOP) begin
                commonMem[effAddr[3:0]] <= regWdata;
                if (regPair) begin
                    commonMem[pairAddr[3:0]] <= regWdataLow;
                end
            end else if (effAddr < `PRFA_BANK_BASE) begin
                sysMem[effAddr[3:0]] <= regWdata;
                if (regPair) begin
                    sysMem[pairAddr[3:0]] <= regWdataLow;
                end
            end else begin
                bankMem[{bank_ff, effAddr[4:0]}] <= regWdata;
                if (regPair) begin
                    bankMem[{bank_ff, pairAddr[4:0]}] <= regWdataLow;
                end
            end
        end
    end

    // Read data registered; pointer locations mirror live registers
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= 8'h00;
            regRdataLow <= 8'h00;
            regErr <= 1'b0;
            regAck <= 1'b0;
        end else begin
            regAck <= regReq;
            regErr <= regReq && !legal;
            if (regReq && !regWrite && legal) begin
                if (!inSet1) begin
                    regRdata <= pagedMem[pagedIdx];
                    regRdataLow <= pagedMem[{pageSel[2:0], pairAddr}];
                end else if (effAddr <= `PRFA_COMMON_TOP) begin
                    regRdata <= commonMem[effAddr[3:0]];
                    regRdataLow <= commonMem[pairAddr[3:0]];
                end else if (effAddr == `PRFA_WP_LOW_ADDR) begin
                    regRdata <= workingPtrLow_ff;
                    regRdataLow <= workingPtrHigh_ff;
                end else if (effAddr == `PRFA_WP_HIGH_ADDR) begin
                    regRdata <= workingPtrHigh_ff;
                    regRdataLow <= 8'h00;
                end else if (effAddr == `PRFA_PAGE_PTR_ADDR) begin
                    regRdata <= pageSelect_ff;
                    regRdataLow <= 8'h00;
                end else if (effAddr < `PRFA_BANK_BASE) begin
                    regRdata <= sysMem[effAddr[3:0]];
                    regRdataLow <= sysMem[pairAddr[3:0]];
                end else begin
                    regRdata <= bankMem[{bank_ff, effAddr[4:0]}];
                    regRdataLow <= bankMem[{bank_ff, pairAddr[4:0]}];
                end
            end else if (regReq) begin
                // Illegal or write cycle returns zero
                regRdata <= 8'h00;
                regRdataLow <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// >>> src/prfa_regs.vh
// Purpose: Constants for the paged register file address decoder
// Assumes: 8-bit register bus, 16-bit program address bus
// Notes: Offsets are register-file byte addresses
`ifndef PRFA_REGS_VH
`define PRFA_REGS_VH
`define PRFA_RESET_PC 16'h0100
`define PRFA_VECTOR_TOP 16'h00FF
`define PRFA_ROM_TOP 16'hBFFF
`define PRFA_SET1_BASE 8'hC0
`define PRFA_COMMON_TOP 8'hCF
`define PRFA_SYS_BASE 8'hD0
`define PRFA_BANK_BASE 8'hE0
`define PRFA_WP_LOW_ADDR 8'hD6
`define PRFA_WP_HIGH_ADDR 8'hD7
`define PRFA_PAGE_PTR_ADDR 8'hDF
`define PRFA_WP_LOW_RST 8'hC0
`define PRFA_WP_HIGH_RST 8'hC8
`define PRFA_PAGE_PTR_RST 8'h00
`define PRFA_PAGE_COUNT 4'h8
`define PRFA_WR_NIBBLE 4'hC
`define PRFA_DISPLAY_BASE 8'h00
`define PRFA_DISPLAY_LEN 8'h14
`define PRFA_MODE_REG 3'h0
`define PRFA_MODE_WREG4 3'h1
`define PRFA_MODE_INDIRECT 3'h2
`define PRFA_MODE_INDEXED 3'h3
`endif

// >>> src/prfa_wreg_map.v
// Purpose: Forms a full register address from a working register nibble
// Assumes: Pointers hold slice base in their upper five bits
// Notes: Pure combinational, no state
`timescale 1ns/1ps
`default_nettype none
module prfa_wreg_map (
    input wire [3:0] wrNibble,
    input wire [7:0] workingPtrLow,
    input wire [7:0] workingPtrHigh,
    output wire [7:0] fullAddr
);
    // Bit 3 picks the pointer; its top five bits meet the low three bits
    assign fullAddr = wrNibble[3] ? {workingPtrHigh[7:3], wrNibble[2:0]}
                                  : {workingPtrLow[7:3], wrNibble[2:0]};
endmodule
`default_nettype wire

// >>> testbench/prfa_core_model.sv
// Purpose: CPU core model issuing register bus accesses
// Assumes: Requests start 1 ns after a rising edge
// Notes: Address and data lines are inverted once the taking edge has passed
`timescale 1ns/1ps
`default_nettype none
module prfa_core_model (
    input wire logic clk,
    output logic regReq, regWrite, regPair,
    output logic [2:0] regMode,
    output logic [7:0] regAddr, regWdata, regWdataLow
);
    // Idle bus from time zero
    initial {regReq, regWrite, regPair, regMode, regAddr} = 14'h0000;
    initial {regWdata, regWdataLow} = 16'h0000;
    // One access held to its taking edge; address and data inverted after it, request dropped, other control lines held
    task automatic acc(input logic w, p, input logic [2:0] m,
            input logic [7:0] a, d, dl);
        @(posedge clk) #1;
        {regReq, regWrite, regPair, regMode} = {1'b1, w, p, m};
        regAddr = a;
        {regWdata, regWdataLow} = {d, dl};
        @(posedge clk) #1;
        regReq = 1'b0;
        {regAddr, regWdata, regWdataLow} = ~{a, d, dl};
    endtask
endmodule
`default_nettype wire

// >>> testbench/prfa_decoder_chk.sv
// Purpose: Port-level checks for the paged register decoder
// Assumes: One clock domain, reset active high
// Notes: Both bank strobes at once is left unchecked
`timescale 1ns/1ps
`default_nettype none
module prfa_decoder_chk (
    input wire logic clk, sys_rst, fetchNext, jumpValid, progVector,
    input wire logic regReq, regPair, regAck, regErr, bankSel, displayHit,
    input wire logic setPointerInstr, setPointerSel,
    input wire logic selectBankZeroInstr, selectBankOneInstr,
    input wire logic [15:0] jumpAddr, progAddr,
    input wire logic [2:0] regMode,
    input wire logic [7:0] regAddr, setPointerVal, workingPtrLow
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Plain step and refused request shapes
    sequence fetch_only; fetchNext && !jumpValid; endsequence
    sequence bad_req;
        regReq && ((regPair && regAddr[0]) || (regMode[2] && regAddr >= 8'hC0));
    endsequence
    fetch_step_a: assert property (fetch_only |=>
        progAddr == $past(progAddr) + 16'h0001) else $error("pc step");
    jump_load_a: assert property (jumpValid |=>
        progAddr == $past(jumpAddr)) else $error("pc jump");
    vector_flag_a: assert property (
        progVector == (progAddr <= 16'h00FF)) else $error("vector flag");
    ack_next_a: assert property (regReq |=> regAck)
        else $error("no ack");
    ack_pulse_a: assert property (!regReq |=> !regAck)
        else $error("stray ack");
    refuse_bad_a: assert property (bad_req |=> regErr)
        else $error("no refusal");
    ptr_set_a: assert property (setPointerInstr && !setPointerSel
        |=> workingPtrLow == $past(setPointerVal)) else $error("ptr set");
    bank_one_a: assert property (selectBankOneInstr
        && !selectBankZeroInstr |=> bankSel) else $error("bank one");
    display_hit_a: assert property (regMode == 3'h0
        && regAddr < 8'hC0 |-> displayHit == (regReq && regAddr < 8'h14))
        else $error("display flag");
endmodule
bind prfa_decoder prfa_decoder_chk i_chk (.clk(clk), .sys_rst(sys_rst),
    .fetchNext(fetchNext), .jumpValid(jumpValid), .progVector(progVector),
    .regReq(regReq), .regPair(regPair), .regAck(regAck), .regErr(regErr),
    .bankSel(bankSel), .setPointerInstr(setPointerInstr),
    .setPointerSel(setPointerSel), .selectBankZeroInstr(selectBankZeroInstr),
    .selectBankOneInstr(selectBankOneInstr), .jumpAddr(jumpAddr),
    .progAddr(progAddr), .regMode(regMode), .regAddr(regAddr),
    .setPointerVal(setPointerVal), .workingPtrLow(workingPtrLow),
    .displayHit(displayHit));
`default_nettype wire

// >>> testbench/prfa_decoder_tb.sv
// Purpose: Scenario bench for the paged register decoder
// Assumes: 200 MHz clock, inputs moved 1 ns after the edge
// Notes: Storage is only read back after the bench wrote it
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module prfa_decoder_tb;
    logic clk = 1'b0, sys_rst = 1'b1, fetchNext = 1'b0, jumpValid = 1'b0;
    logic setPointerInstr = 1'b0, setPointerSel = 1'b0;
    logic selectBankZeroInstr = 1'b0, selectBankOneInstr = 1'b0;
    logic [15:0] jumpAddr = 16'h0000;
    logic [7:0] setPointerVal = 8'h00;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    wire regReq, regWrite, regPair, progVector, progInRange, regErr, regAck;
    wire bankSel, displayHit;
    wire [2:0] regMode;
    wire [15:0] progAddr;
    wire [7:0] regAddr, regWdata, regWdataLow, regRdata, regRdataLow;
    wire [7:0] workingPtrLow, workingPtrHigh, pageSelectPointer;
    prfa_core_model i_core (.clk(clk), .regReq(regReq), .regWrite(regWrite),
        .regPair(regPair), .regMode(regMode), .regAddr(regAddr),
        .regWdata(regWdata), .regWdataLow(regWdataLow));
    prfa_decoder i_dut (.clk(clk), .sys_rst(sys_rst), .fetchNext(fetchNext),
        .jumpValid(jumpValid), .jumpAddr(jumpAddr), .progAddr(progAddr),
        .progVector(progVector), .progInRange(progInRange), .regReq(regReq),
        .regWrite(regWrite), .regPair(regPair), .regMode(regMode),
        .regAddr(regAddr), .regWdata(regWdata), .regWdataLow(regWdataLow),
        .setPointerInstr(setPointerInstr), .setPointerSel(setPointerSel),
        .setPointerVal(setPointerVal), .regRdata(regRdata),
        .selectBankZeroInstr(selectBankZeroInstr), .regErr(regErr),
        .selectBankOneInstr(selectBankOneInstr), .regAck(regAck),
        .regRdataLow(regRdataLow), .workingPtrLow(workingPtrLow),
        .workingPtrHigh(workingPtrHigh), .bankSel(bankSel),
        .pageSelectPointer(pageSelectPointer), .displayHit(displayHit));
    initial forever #2.5 clk = ~clk;
    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            close_out;
        end
    end
    // Verdict and end of run
    task automatic close_out;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bus helpers: one-cycle strobes, code 0 fetch, 1 jump, 2/3 ptr, 4/5 bank
    task automatic ins(input int k, input logic [15:0] v);
        @(posedge clk) #1;
        {jumpAddr, setPointerVal, setPointerSel} = {v, v[7:0], k[0]};
        {fetchNext, jumpValid, setPointerInstr} = {k == 0, k == 1, k[3:1] == 1};
        {selectBankZeroInstr, selectBankOneInstr} = {k == 4, k == 5};
        @(posedge clk) #1;
        {fetchNext, jumpValid, setPointerInstr} = 3'h0;
        {selectBankZeroInstr, selectBankOneInstr} = 2'h0;
    endtask
    task automatic wr(input logic [2:0] m, input logic [7:0] a, d);
        i_core.acc(1'b1, 1'b0, m, a, d, 8'h00);
    endtask
    task automatic rd(input logic [2:0] m, input logic [7:0] a, e);
        i_core.acc(1'b0, 1'b0, m, a, 8'h00, 8'h00);
        `CK("regRdata", e, regRdata)
    endtask
    // Scenarios
    task automatic t_reset;
        `CK("progAddr", 16'h0100, progAddr)
        `CK("ptrs", 16'hC0C8, {workingPtrLow, workingPtrHigh})
        `CK("page/bank", 9'h000, {pageSelectPointer, bankSel})
        rd(3'h0, 8'hD7, 8'hC8);
    endtask
    task automatic t_prog;
        ins(1, 16'h00FF);
        `CK("vecTop", 2'h3, {progVector, progInRange})
        ins(0, 16'h0000);
        `CK("pastVec", 17'h00100, {progVector, progAddr})
        ins(1, 16'hBFFF);
        `CK("romTop", 1'b1, progInRange)
        ins(0, 16'h0000);
        `CK("romEnd", 1'b0, progInRange)
    endtask
    task automatic t_work;
        wr(3'h0, 8'h85, 8'h5A);
        wr(3'h0, 8'h7B, 8'hA5);
        wr(3'h0, 8'hD6, 8'h80);
        ins(3, 16'h0078);
        `CK("ptrs", 16'h8078, {workingPtrLow, workingPtrHigh})
        rd(3'h1, 8'h05, 8'h5A);
        rd(3'h1, 8'h0B, 8'hA5);
        rd(3'h0, 8'hCB, 8'hA5);
    endtask
    task automatic t_bank;
        ins(4, 16'h0000);
        wr(3'h0, 8'hE5, 8'h01);
        ins(5, 16'h0000);
        wr(3'h0, 8'hE5, 8'h02);
        wr(3'h2, 8'hE5, 8'h03);
        rd(3'h0, 8'hE5, 8'h02);
        ins(4, 16'h0000);
        rd(3'h0, 8'hE5, 8'h01);
        rd(3'h3, 8'hE5, 8'h03);
        ins(2, 16'h00E0);
        rd(3'h1, 8'h05, 8'h01);
        ins(2, 16'h00C0);
        wr(3'h1, 8'h03, 8'h77);
        wr(3'h2, 8'hC3, 8'h66);
        rd(3'h1, 8'h03, 8'h77);
        rd(3'h2, 8'hC3, 8'h66);
        `CK("set2Err", 1'b0, regErr)
    endtask
    task automatic t_pair;
        i_core.acc(1'b1, 1'b1, 3'h0, 8'h40, 8'h12, 8'h34);
        i_core.acc(1'b0, 1'b1, 3'h0, 8'h40, 8'h00, 8'h00);
        `CK("pair", 16'h1234, {regRdata, regRdataLow})
        rd(3'h5, 8'h41, 8'h34);
        i_core.acc(1'b0, 1'b1, 3'h0, 8'h41, 8'h00, 8'h00);
        `CK("oddPair", 1'b1, regErr)
        i_core.acc(1'b1, 1'b1, 3'h0, 8'hD6, 8'hC0, 8'hC8);
        `CK("pairPtrs", 16'hC0C8, {workingPtrLow, workingPtrHigh})
        wr(3'h0, 8'h13, 8'h5C);
        rd(3'h0, 8'h13, 8'h5C);
        rd(3'h4, 8'hE0, 8'h00);
        `CK("modeErr", 1'b1, regErr)
    endtask
    task automatic t_page;
        wr(3'h0, 8'h20, 8'h22);
        wr(3'h0, 8'hDF, 8'h10);
        wr(3'h0, 8'h20, 8'h11);
        rd(3'h0, 8'h20, 8'h22);
        wr(3'h0, 8'hDF, 8'h11);
        rd(3'h0, 8'h20, 8'h11);
        wr(3'h0, 8'hDF, 8'h08);
        rd(3'h0, 8'h20, 8'h00);
        `CK("pageErr", 1'b1, regErr)
    endtask
    // Main sequence: 16 cycles of reset, released off the edge
    initial begin
        repeat (16) @(posedge clk);
        #1 sys_rst = 1'b0;
        t_reset;
        t_prog;
        t_work;
        t_bank;
        t_pair;
        t_page;
        close_out;
    end
endmodule
`default_nettype wire
